//--- inc/dps_pkg.sv
// Shared constants and carrier types for the priority store
`default_nettype none
package dps_pkg;
  // Register frame offsets and window sizes in words
  localparam logic [15:0] DPS_STD_BASE = 16'h0400;
  localparam logic [15:0] DPS_EXT_BASE = 16'h2000;
  localparam int DPS_STD_SPAN = 255;
  localparam int DPS_EXT_SPAN = 256;
  // Words per unit of the size fields
  localparam int DPS_WORDS_PER_UNIT = 8;
  // Banked words and the highest banking core index
  localparam int DPS_BANKED_WORDS = 8;
  localparam int DPS_BANK_CORE_LIMIT = 7;
  // Lane layout of a priority word
  localparam int DPS_LANES = 4;
  localparam int DPS_LANE_W = 8;
  // Warm reset value of standard words
  localparam logic [31:0] DPS_STD_RESET = 32'h0000_0000;
  // First extended interrupt number
  localparam logic [12:0] DPS_EXT_ID_BASE = 13'h1000;
  // Least number of implemented priority bits
  localparam int DPS_MIN_PRIO_BITS = 4;
  // Group codes: modifier bit, then status bit
  localparam logic [1:0] DPS_GRP_SG0 = 2'h0;
  localparam logic [1:0] DPS_GRP_NSG1 = 2'h1;
  localparam logic [1:0] DPS_GRP_SG1 = 2'h2;
  localparam logic [1:0] DPS_GRP_NSG1R = 2'h3;

  // One register access from a core
  typedef struct packed {
    logic valid;
    logic write;
    logic nonsecure;
    logic [7:0] core;
    logic [15:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } dps_req_t;

  // Distributor configuration levels
  typedef struct packed {
    logic single_security_select;
    logic are_secure;
    logic are_nonsecure;
    logic [4:0] interrupt_lines_count;
    logic extended_range_support;
    logic [4:0] extended_range_size;
  } dps_cfg_t;

  // Access answer
  typedef struct packed {
    logic valid;
    logic [31:0] rdata;
  } dps_rsp_t;
endpackage
`default_nettype wire

//--- logic/dps_addr_decode.sv
// Window decoder: byte address to priority word index
`timescale 1ns/100ps
`default_nettype none
module dps_addr_decode #(
  parameter logic [15:0] BASE = 16'h0400, // First byte of the window
  parameter int SPAN = 255 // Words in the window
) (
  input wire logic [15:0] addr,
  output logic hit,
  output logic [7:0] word_idx
);
  logic [15:0] offset; // Distance from window base

  // Offset, word index and window hit
  always_comb begin
    offset = addr - BASE;
    word_idx = offset[9:2];
    hit = (addr >= BASE) && (int'(offset[15:2]) < SPAN);
  end
endmodule
`default_nettype wire

//--- logic/dps_lane_filter.sv
// One priority byte lane: security, reserved and width filtering
`timescale 1ns/100ps
`default_nettype none
module dps_lane_filter
  import dps_pkg::*;
#(
  parameter int PRIO_BITS = 8 // Implemented bits, from the top
) (
  input wire logic [7:0] stored,
  input wire logic [7:0] wbyte,
  input wire logic sel,
  input wire logic write,
  input wire logic nonsecure,
  input wire logic single_security,
  input wire logic [1:0] grp,
  input wire logic are_secure,
  input wire logic are_nonsecure,
  input wire logic implemented,
  input wire logic bank_word,
  input wire logic is_ext,
  output logic [7:0] rd_byte,
  output logic wr_en,
  output logic [7:0] wr_byte
);
  localparam logic [7:0] MASK = 8'(9'h1ff << (8 - PRIO_BITS)); // Kept bits
  logic secure_grp; // Interrupt owned by the secure state
  logic are_lane; // Affinity routing for its state
  logic blocked; // Field reads zero, ignores writes
  logic ns_view; // Shifted non-secure view applies

  // Filter decision and views
  always_comb begin
    secure_grp = !single_security && ((grp == DPS_GRP_SG0) || (grp == DPS_GRP_SG1));
    are_lane = secure_grp || single_security ? are_secure : are_nonsecure;
    blocked = !implemented
      || (bank_word && are_lane)
      || (is_ext && !are_lane)
      || (nonsecure && secure_grp);
    ns_view = nonsecure && !single_security && !secure_grp;
    if (blocked || !sel) begin
      rd_byte = 8'h00;
    end else if (ns_view) begin
      rd_byte = {stored[6:0], 1'b0} & MASK;
    end else begin
      rd_byte = stored & MASK;
    end
    wr_en = write && sel && !blocked;
    wr_byte = (ns_view ? {1'b1, wbyte[7:1]} : wbyte) & MASK;
  end
endmodule
`default_nettype wire

//--- logic/dps_priority_store.sv
// Priority store: banked and shared priority words with access filtering
`timescale 1ns/100ps
`default_nettype none
module dps_priority_store #(
  parameter int NUM_CORES = 4, // Cores holding banked copies
  parameter int MAX_STD_WORDS = 32, // Standard words built
  parameter int MAX_EXT_WORDS = 32, // Extended words built
  parameter int PRIO_BITS = 8, // Implemented priority bits
  parameter bit EXT_PRESENT = 1'b1 // Extended interrupt feature built
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire dps_pkg::dps_req_t REQ,
  input wire dps_pkg::dps_cfg_t CFG,
  input wire logic [4*MAX_STD_WORDS-1:0] GRP_STATUS,
  input wire logic [4*MAX_STD_WORDS-1:0] GRP_MODIFIER,
  input wire logic [4*MAX_EXT_WORDS-1:0] EXT_GRP_STATUS,
  input wire logic [4*MAX_EXT_WORDS-1:0] EXT_GRP_MODIFIER,
  input wire logic [12:0] QUERY_ID,
  input wire logic [7:0] QUERY_CORE,
  output var dps_pkg::dps_rsp_t RSP,
  output logic [7:0] QUERY_PRIO
);
  import dps_pkg::*;

  // Storage sizes
  localparam int STD_ENTRIES = NUM_CORES * DPS_BANKED_WORDS + MAX_STD_WORDS - DPS_BANKED_WORDS;
  localparam int SIW = $clog2(STD_ENTRIES);
  localparam int EIW = (MAX_EXT_WORDS > 1) ? $clog2(MAX_EXT_WORDS) : 1;
  localparam logic [7:0] MASK = 8'(9'h1ff << (8 - PRIO_BITS));

  // Standard words: banked copies first, then shared words
  logic [31:0] std_mem_r [STD_ENTRIES];
  logic [31:0] std_mem_nxt [STD_ENTRIES];
  // Extended words
  logic [31:0] ext_mem_r [MAX_EXT_WORDS];
  logic [31:0] ext_mem_nxt [MAX_EXT_WORDS];
  // Access answer
  dps_rsp_t rsp_r;
  dps_rsp_t rsp_nxt;
  // Looked-up priority
  logic [7:0] query_r;
  logic [7:0] query_nxt;

  // Decoder results
  logic std_hit; // Address in standard window
  logic ext_hit; // Address in extended window
  logic [7:0] std_widx; // Standard word index
  logic [7:0] ext_widx; // Extended word index
  // Access qualification
  logic std_word_ok; // Word implemented
  logic std_banked; // Word is a banked one
  logic core_ok; // Core may own a banked copy
  logic std_sel; // Standard word selected
  logic ext_sel; // Extended word selected
  logic [SIW-1:0] sidx; // Standard storage index
  logic [EIW-1:0] eidx; // Extended storage index
  logic [31:0] cur_word; // Stored word addressed
  logic acc_write; // Write request this cycle
  // Lane results
  logic [1:0] lane_grp [DPS_LANES];
  logic [7:0] rd_byte [DPS_LANES];
  logic [7:0] wr_byte [DPS_LANES];
  logic wr_en [DPS_LANES];
  // Lookup path
  logic q_ext; // Lookup in extended range
  logic [12:0] q_rel; // Id relative to its range
  logic [31:0] q_word; // Word holding the field
  int q_w; // Word number of the lookup

  // Window decoders for both ranges
  dps_addr_decode #(
    .BASE(DPS_STD_BASE),
    .SPAN(DPS_STD_SPAN)
  ) u_std_dec (
    .addr(REQ.addr),
    .hit(std_hit),
    .word_idx(std_widx)
  );

  dps_addr_decode #(
    .BASE(DPS_EXT_BASE),
    .SPAN(DPS_EXT_SPAN)
  ) u_ext_dec (
    .addr(REQ.addr),
    .hit(ext_hit),
    .word_idx(ext_widx)
  );

  // Which word the access reaches
  always_comb begin
    acc_write = REQ.valid && REQ.write;
    // Standard words present: eight per lines unit
    std_word_ok = (int'(std_widx) < DPS_WORDS_PER_UNIT * (int'(CFG.interrupt_lines_count) + 1))
      && (int'(std_widx) < MAX_STD_WORDS);
    std_banked = int'(std_widx) < DPS_BANKED_WORDS;
    // Cores above seven or without a copy read zero
    core_ok = (int'(REQ.core) <= DPS_BANK_CORE_LIMIT) && (int'(REQ.core) < NUM_CORES);
    std_sel = std_hit && std_word_ok && (!std_banked || core_ok);
    if (std_banked) begin
      sidx = SIW'(int'(REQ.core) * DPS_BANKED_WORDS + int'(std_widx));
    end else begin
      sidx = SIW'(NUM_CORES * DPS_BANKED_WORDS + int'(std_widx) - DPS_BANKED_WORDS);
    end
    // Extended words only when built and advertised
    ext_sel = EXT_PRESENT && CFG.extended_range_support && ext_hit
      && (int'(ext_widx) < DPS_WORDS_PER_UNIT * (int'(CFG.extended_range_size) + 1))
      && (int'(ext_widx) < MAX_EXT_WORDS);
    eidx = EIW'(ext_widx);
    // Current contents, zero when nothing is selected
    if (std_sel) begin
      cur_word = std_mem_r[sidx];
    end else if (ext_sel) begin
      cur_word = ext_mem_r[eidx];
    end else begin
      cur_word = 32'h0000_0000;
    end
  end

  // One filter per byte lane
  for (genvar k = 0; k < DPS_LANES; k++) begin : g_lane
    // Group of the interrupt in this lane
    always_comb begin
      int gid;
      gid = 0;
      lane_grp[k] = DPS_GRP_SG0;
      if (std_sel) begin
        gid = int'(std_widx) * DPS_LANES + k;
        lane_grp[k] = {GRP_MODIFIER[gid], GRP_STATUS[gid]};
      end else if (ext_sel) begin
        gid = int'(ext_widx) * DPS_LANES + k;
        lane_grp[k] = {EXT_GRP_MODIFIER[gid], EXT_GRP_STATUS[gid]};
      end
    end

    dps_lane_filter #(
      .PRIO_BITS(PRIO_BITS)
    ) u_lane (
      .stored(cur_word[k*DPS_LANE_W +: DPS_LANE_W]),
      .wbyte(REQ.wdata[k*DPS_LANE_W +: DPS_LANE_W]),
      .sel(REQ.be[k]),
      .write(acc_write),
      .nonsecure(REQ.nonsecure),
      .single_security(CFG.single_security_select),
      .grp(lane_grp[k]),
      .are_secure(CFG.are_secure),
      .are_nonsecure(CFG.are_nonsecure),
      .implemented(std_sel || ext_sel),
      .bank_word(std_sel && std_banked),
      .is_ext(ext_sel),
      .rd_byte(rd_byte[k]),
      .wr_en(wr_en[k]),
      .wr_byte(wr_byte[k])
    );
  end

  // Next contents of the standard words
  always_comb begin
    std_mem_nxt = std_mem_r;
    if (std_sel) begin
      // Only enabled lanes change; others keep their byte
      for (int k = 0; k < DPS_LANES; k++) begin
        if (wr_en[k]) begin
          std_mem_nxt[sidx][k*DPS_LANE_W +: DPS_LANE_W] = wr_byte[k];
        end
      end
    end
  end

  // Next contents of the extended words
  always_comb begin
    ext_mem_nxt = ext_mem_r;
    if (ext_sel) begin
      for (int k = 0; k < DPS_LANES; k++) begin
        if (wr_en[k]) begin
          ext_mem_nxt[eidx][k*DPS_LANE_W +: DPS_LANE_W] = wr_byte[k];
        end
      end
    end
  end

  // Answer: one cycle after every access
  always_comb begin
    rsp_nxt.valid = REQ.valid;
    // Unmapped or filtered lanes read zero
    if (REQ.valid && !REQ.write) begin
      rsp_nxt.rdata = {rd_byte[3], rd_byte[2], rd_byte[1], rd_byte[0]};
    end else begin
      rsp_nxt.rdata = 32'h0000_0000;
    end
  end

  // Priority lookup for the distribution logic
  always_comb begin
    q_ext = QUERY_ID >= DPS_EXT_ID_BASE;
    q_rel = q_ext ? QUERY_ID - DPS_EXT_ID_BASE : QUERY_ID;
    q_w = int'(q_rel[12:2]);
    q_word = 32'h0000_0000;
    if (q_ext) begin
      // Extended word (id - 4096) / 4
      if (EXT_PRESENT && CFG.extended_range_support && (q_w < MAX_EXT_WORDS)
          && (q_w < DPS_WORDS_PER_UNIT * (int'(CFG.extended_range_size) + 1))) begin
        q_word = ext_mem_r[EIW'(q_w)];
      end
    end else if (q_w < DPS_BANKED_WORDS) begin
      // Banked word of the named core
      if ((int'(QUERY_CORE) <= DPS_BANK_CORE_LIMIT) && (int'(QUERY_CORE) < NUM_CORES)) begin
        q_word = std_mem_r[SIW'(int'(QUERY_CORE) * DPS_BANKED_WORDS + q_w)];
      end
    end else if ((q_w < MAX_STD_WORDS)
        && (q_w < DPS_WORDS_PER_UNIT * (int'(CFG.interrupt_lines_count) + 1))) begin
      q_word = std_mem_r[SIW'(NUM_CORES * DPS_BANKED_WORDS + q_w - DPS_BANKED_WORDS)];
    end
    // Whole byte taken from one stored copy: old or new, never mixed
    query_nxt = q_word[int'(QUERY_ID[1:0])*DPS_LANE_W +: DPS_LANE_W] & MASK;
  end

  // Standard words, answer and lookup registers
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < STD_ENTRIES; i++) begin
        std_mem_r[i] <= DPS_STD_RESET;
      end
      rsp_r <= '0;
      query_r <= 8'h00;
    end else begin
      std_mem_r <= std_mem_nxt;
      rsp_r <= rsp_nxt;
      query_r <= query_nxt;
    end
  end

  // Extended words carry no reset value
  always_ff @(posedge CLK_SYS) begin
    ext_mem_r <= ext_mem_nxt;
  end

  // Outputs straight from flip-flops
  always_comb begin
    RSP = rsp_r;
    QUERY_PRIO = query_r;
  end
endmodule
`default_nettype wire

//--- testbench/dps_priority_store_assertions.sv
// Port checks for the priority store
`timescale 1ns/100ps
`default_nettype none
module dps_priority_store_assertions
  import dps_pkg::*;
#(
  parameter int PRIO_BITS = 8 // Kept bits, from the top
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire dps_pkg::dps_req_t REQ,
  input wire dps_pkg::dps_cfg_t CFG,
  input wire dps_pkg::dps_rsp_t RSP
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  logic rd; // Read taken this edge
  logic [15:0] soff; // Offset in standard window
  logic [15:0] eoff; // Offset in extended window
  logic std_hit, ext_hit, std_far, ext_far;
  logic [7:0] lmask; // Kept bits of a lane
  logic wrote_r, wrote_nxt; // Standard write seen since reset
  assign rd = REQ.valid && !REQ.write;
  assign soff = REQ.addr - DPS_STD_BASE;
  assign eoff = REQ.addr - DPS_EXT_BASE;
  assign std_hit = REQ.addr >= DPS_STD_BASE && soff < 16'(4 * DPS_STD_SPAN);
  assign ext_hit = REQ.addr >= DPS_EXT_BASE && eoff < 16'(4 * DPS_EXT_SPAN);
  assign std_far = int'(soff[9:2]) >= 8 * (int'(CFG.interrupt_lines_count) + 1);
  assign ext_far = int'(eoff[9:2]) >= 8 * (int'(CFG.extended_range_size) + 1);
  assign lmask = 8'hff << (8 - PRIO_BITS);
  // Remember a standard write until the next reset
  always_comb begin
    wrote_nxt = wrote_r | (REQ.valid & REQ.write & std_hit);
  end
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      wrote_r <= 1'b0;
    end else begin
      wrote_r <= wrote_nxt;
    end
  end
  sequence s_zero;
    RSP.rdata == 32'h0;
  endsequence
  property p_answer;
    1'b1 |=> RSP.valid == $past(REQ.valid);
  endproperty
  a_answer: assert property (p_answer) else $error("answer pulse wrong");
  property p_lanes;
    rd |=> (RSP.rdata & ~{{8{$past(REQ.be[3])}}, {8{$past(REQ.be[2])}},
      {8{$past(REQ.be[1])}}, {8{$past(REQ.be[0])}}}) == 32'h0;
  endproperty
  a_lanes: assert property (p_lanes) else $error("disabled lane not zero");
  property p_width;
    RSP.valid |-> (RSP.rdata & ~{4{lmask}}) == 32'h0;
  endproperty
  a_width: assert property (p_width) else $error("low bits not zero");
  property p_reset;
    rd && std_hit && !wrote_r |=> s_zero;
  endproperty
  a_reset: assert property (p_reset) else $error("word not clear after reset");
  property p_unmapped;
    rd && !std_hit && !ext_hit |=> s_zero;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_std_count;
    rd && std_hit && std_far |=> s_zero;
  endproperty
  a_std_count: assert property (p_std_count) else $error("word past count");
  property p_bank;
    rd && std_hit && soff[9:2] < 8'h08 && REQ.core > 8'h07 |=> s_zero;
  endproperty
  a_bank: assert property (p_bank) else $error("high core sees bank");
  property p_aff;
    rd && std_hit && soff[9:2] < 8'h08 && CFG.are_secure && CFG.are_nonsecure |=> s_zero;
  endproperty
  a_aff: assert property (p_aff) else $error("banked word under affinity");
  property p_ext_off;
    rd && ext_hit && !CFG.extended_range_support |=> s_zero;
  endproperty
  a_ext_off: assert property (p_ext_off) else $error("extended without support");
  property p_ext_count;
    rd && ext_hit && ext_far |=> s_zero;
  endproperty
  a_ext_count: assert property (p_ext_count) else $error("extended past count");
  c_byte_wr: cover property (REQ.valid && REQ.write && REQ.be == 4'h2);
  c_ns_rd: cover property (rd && REQ.nonsecure);
  c_ext_rd: cover property (rd && ext_hit && CFG.extended_range_support);
endmodule
bind dps_priority_store dps_priority_store_assertions #(.PRIO_BITS(PRIO_BITS)) i_chk (
  .CLK_SYS(CLK_SYS), .RST(RST), .REQ(REQ), .CFG(CFG), .RSP(RSP));
`default_nettype wire

//--- testbench/dps_core_model.sv
// Requesting core: one register access per call
`timescale 1ns/100ps
`default_nettype none
module dps_core_model
  import dps_pkg::*;
(
  input wire logic CLK_SYS,
  input wire dps_pkg::dps_rsp_t RSP,
  output var dps_pkg::dps_req_t REQ
);
  initial REQ = '0; // Idle at time zero
  // Drive after a falling edge, hold over the taking edge, then release
  task automatic access(input logic wr, input logic ns, input logic [7:0] core,
      input logic [15:0] addr, input logic [3:0] be, input logic [31:0] wdata,
      output logic [31:0] rdata);
    @(negedge CLK_SYS);
    REQ = '{1'b1, wr, ns, core, addr, be, wdata};
    @(negedge CLK_SYS);
    rdata = RSP.valid ? RSP.rdata : 32'hdead_0bad; // Missing answer never matches
    REQ = '{1'b0, ~wr, ~ns, ~core, ~addr, ~be, ~wdata}; // Released lines move
  endtask
endmodule
`default_nettype wire

//--- testbench/tb_dps_priority_store.sv
// Self-checking bench for the priority store
`timescale 1ns/100ps
`default_nettype none
module tb_dps_priority_store;
  import dps_pkg::*;
  logic clk_sys, rst;
  dps_req_t req;
  dps_cfg_t cfg;
  dps_rsp_t rsp;
  logic [127:0] grp_st, grp_md, egrp_st, egrp_md; // Group bits per id
  logic [12:0] query_id;
  logic [7:0] query_core, query_prio;
  logic [31:0] rdat;
  int err_count, tests_run;
  dps_priority_store #(.PRIO_BITS(6)) i_dps_priority_store (.CLK_SYS(clk_sys), .RST(rst),
    .REQ(req), .CFG(cfg), .GRP_STATUS(grp_st), .GRP_MODIFIER(grp_md),
    .EXT_GRP_STATUS(egrp_st), .EXT_GRP_MODIFIER(egrp_md), .QUERY_ID(query_id),
    .QUERY_CORE(query_core), .RSP(rsp), .QUERY_PRIO(query_prio));
  dps_core_model i_dps_core_model (.CLK_SYS(clk_sys), .RSP(rsp), .REQ(req));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: word %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: prio %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic ns, input logic [7:0] c, input logic [15:0] a,
      input logic [3:0] be, input logic [31:0] d);
    i_dps_core_model.access(1'b1, ns, c, a, be, d, rdat);
    chk32(rdat, 32'h0);
  endtask
  task automatic rd(input logic ns, input logic [7:0] c, input logic [15:0] a,
      input logic [3:0] be, input logic [31:0] e);
    i_dps_core_model.access(1'b0, ns, c, a, be, 32'h0, rdat);
    chk32(rdat, e);
  endtask
  task automatic qry(input logic [12:0] id, input logic [7:0] c, input logic [7:0] e);
    @(negedge clk_sys);
    query_id = id;
    query_core = c;
    @(negedge clk_sys);
    chk8(query_prio, e);
  endtask
  // Clear words after reset
  task automatic t_reset;
    rd(1'b0, 8'h00, 16'h0400, 4'hf, 32'h0);
    rd(1'b0, 8'h00, 16'h041c, 4'hf, 32'h0);
    qry(13'h0005, 8'h00, 8'h00);
  endtask
  // Lane placement, byte access and kept bits
  task automatic t_lanes;
    wr(1'b0, 8'h00, 16'h0408, 4'hf, 32'h4433_2211);
    rd(1'b0, 8'h00, 16'h0408, 4'hf, 32'h4430_2010);
    wr(1'b0, 8'h00, 16'h0408, 4'h2, 32'h0000_aa00);
    rd(1'b0, 8'h00, 16'h0408, 4'hf, 32'h4430_a810);
    rd(1'b0, 8'h00, 16'h0408, 4'h2, 32'h0000_a800);
    qry(13'h0009, 8'h00, 8'ha8);
  endtask
  // Banked copies per core, high cores shut out
  task automatic t_bank;
    wr(1'b0, 8'h00, 16'h0404, 4'hf, 32'h8080_8080);
    rd(1'b0, 8'h01, 16'h0404, 4'hf, 32'h0);
    wr(1'b0, 8'h09, 16'h0404, 4'hf, 32'h4040_4040);
    rd(1'b0, 8'h09, 16'h0404, 4'hf, 32'h0);
    rd(1'b0, 8'h00, 16'h0404, 4'hf, 32'h8080_8080);
    qry(13'h0005, 8'h01, 8'h00);
    qry(13'h0005, 8'h00, 8'h80);
  endtask
  // Words past the lines count and unmapped offsets
  task automatic t_unimpl;
    wr(1'b0, 8'h00, 16'h0420, 4'hf, 32'hffff_ffff);
    rd(1'b0, 8'h00, 16'h0420, 4'hf, 32'h0);
    rd(1'b0, 8'h00, 16'h0100, 4'hf, 32'h0);
    // Second lines unit brings shared word 8, one copy for all cores
    cfg.interrupt_lines_count = 5'h01;
    wr(1'b0, 8'h00, 16'h0420, 4'hf, 32'h5060_7080);
    rd(1'b0, 8'h01, 16'h0420, 4'hf, 32'h5060_7080);
    qry(13'h0022, 8'h02, 8'h60);
  endtask
  // Ids 12..15 in groups secure 0, non-secure 1, secure 1, reserved
  task automatic t_sec;
    @(negedge clk_sys);
    grp_st[15:12] = 4'b1010;
    grp_md[15:12] = 4'b1100;
    wr(1'b0, 8'h00, 16'h040c, 4'hf, 32'h4040_4040);
    rd(1'b1, 8'h00, 16'h040c, 4'hf, 32'h8000_8000);
    wr(1'b1, 8'h00, 16'h040c, 4'hf, 32'hffff_ffff);
    rd(1'b0, 8'h00, 16'h040c, 4'hf, 32'hfc40_fc40);
    @(negedge clk_sys);
    cfg.single_security_select = 1'b1;
    rd(1'b1, 8'h00, 16'h040c, 4'hf, 32'hfc40_fc40);
    @(negedge clk_sys);
    cfg.single_security_select = 1'b0;
  endtask
  // Affinity routing and the extended range
  task automatic t_ext;
    @(negedge clk_sys);
    cfg.are_secure = 1'b1;
    cfg.are_nonsecure = 1'b1;
    egrp_st = '1;
    rd(1'b0, 8'h00, 16'h0408, 4'hf, 32'h0);
    wr(1'b0, 8'h00, 16'h0408, 4'hf, 32'h1111_1111);
    wr(1'b0, 8'h00, 16'h2000, 4'hf, 32'h1234_5678);
    rd(1'b0, 8'h00, 16'h2000, 4'hf, 32'h1034_5478);
    qry(13'h1002, 8'h00, 8'h34);
    rd(1'b0, 8'h00, 16'h2020, 4'hf, 32'h0);
    cfg.are_nonsecure = 1'b0;
    rd(1'b0, 8'h00, 16'h2000, 4'hf, 32'h0);
    cfg.are_nonsecure = 1'b1;
    cfg.extended_range_support = 1'b0;
    rd(1'b0, 8'h00, 16'h2000, 4'hf, 32'h0);
    cfg = '0;
    cfg.extended_range_support = 1'b1;
    rd(1'b0, 8'h00, 16'h0408, 4'hf, 32'h4430_a810);
  endtask
  // Warm reset in mid-run, then a second extended size unit
  task automatic t_warm;
    @(negedge clk_sys);
    cfg.interrupt_lines_count = 5'h01;
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    rd(1'b0, 8'h00, 16'h0408, 4'hf, 32'h0);
    rd(1'b0, 8'h00, 16'h0420, 4'hf, 32'h0);
    qry(13'h0022, 8'h00, 8'h00);
    cfg.are_nonsecure = 1'b1;
    cfg.extended_range_size = 5'h01;
    wr(1'b0, 8'h00, 16'h2020, 4'hf, 32'ha5a5_5a5a);
    rd(1'b0, 8'h00, 16'h2020, 4'hf, 32'ha4a4_5858);
    qry(13'h1020, 8'h00, 8'h58);
  endtask
  task automatic tally_and_finish;
    $display("mismatches %0d of %0d checks", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Hang guard, far beyond the expected run
  initial begin
    repeat (3000) @(posedge clk_sys);
    err_count++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    err_count = 0;
    tests_run = 0;
    rst = 1'b1;
    cfg = '0;
    cfg.extended_range_support = 1'b1;
    grp_st = '0;
    grp_md = '0;
    egrp_st = '0;
    egrp_md = '0;
    query_id = 13'h0;
    query_core = 8'h00;
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    t_reset();
    t_lanes();
    t_bank();
    t_unimpl();
    t_sec();
    t_ext();
    t_warm();
    tally_and_finish();
  end
endmodule
`default_nettype wire
